//--- inc/scan_result_pkg.sv
// constants and carrier types for the column 6/7 multi-key scan result register
package scan_result_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam int          ROWS            = 8;
   localparam int          ROW_SEL_W       = 3;
   localparam logic [7:0]  RESULT_OFFSET   = 8'h2C;
   localparam logic [31:0] RESULT_RESET    = 32'h0000_0000;
   localparam logic [31:0] READ_NONE       = 32'h0000_0000;

   // ----------------------------------------------------------------
   // field layout
   // ----------------------------------------------------------------
   localparam int          VALID_BIT       = 31;
   localparam int          COL7_LSB        = 16;
   localparam int          COL6_LSB        = 0;
   localparam logic [7:0]  ROWS_RESET      = 8'h00;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wr_data;
      logic              wr_en;
      logic              rd_en;
   } reg_req_s;

   typedef struct packed {
      logic            done;
      logic [ROWS-1:0] col7_rows;
      logic [ROWS-1:0] col6_rows;
   } scan_report_s;

endpackage

//--- rtl/row_enable_filter.sv
// forces row bits not enabled for matrix use to zero
`timescale 1ns/1ps
`default_nettype none

module row_enable_filter
   import scan_result_pkg::*;
(
   input  wire logic [ROW_SEL_W-1:0] row_select_i, // rows in use: 0..row_select
   input  wire logic [ROWS-1:0]      rows_i,       // raw row hits
   output logic      [ROWS-1:0]      rows_o        // filtered row hits
);

   // ----------------------------------------------------------------
   // per-row gate
   // ----------------------------------------------------------------
   genvar r;
   generate
      for (r = 0; r < ROWS; r = r + 1) begin : g_row
         assign rows_o[r] = rows_i[r] & (r <= int'(row_select_i));
      end
   endgenerate

endmodule

`default_nettype wire

//--- rtl/multikey_scan_result_cols_6_7.sv
// result register for matrix columns 6 and 7 of the keypad auto-scan
//
// Summary of operation
// - bit 31 goes high when a valid auto scan completes with results stored.
// - with bit 31 low the column fields carry nothing meaningful.
// - while bit 31 is high no activity-triggered scan may update the register, except one reported in the cycle of the read that clears it.
// - captured key data stays unchanged until software reads the register.
// - if neither column 6 nor 7 is a matrix column, bit 31 never sets.
// - a read clears bit 31, re-arming automatic scanning.
// - bits 23:16 show active rows seen while column 7 was driven.
// - bits 7:0 show active rows seen while column 6 was driven.
// - rows not enabled by the control row-select field read as zero.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module multikey_scan_result_cols_6_7
   import scan_result_pkg::*;
(
   input  wire logic                 clock_i,        // 200 MHz clock
   input  wire logic                 sys_rst_i,      // async reset, active high
   input  wire logic [ADDR_W-1:0]    addr_i,         // register address
   input  wire logic [DATA_W-1:0]    wr_data_i,      // write data (ignored here)
   input  wire logic                 wr_en_i,        // write strobe
   input  wire logic                 rd_en_i,        // read strobe
   output logic      [DATA_W-1:0]    rd_data_o,      // read data, cycle after strobe
   input  wire logic                 scan_done_i,    // scan engine: scan finished, pulse
   input  wire logic [ROWS-1:0]      col7_rows_i,    // scan engine: column 7 row hits
   input  wire logic [ROWS-1:0]      col6_rows_i,    // scan engine: column 6 row hits
   input  wire logic                 col7_matrix_i,  // column 7 configured as matrix
   input  wire logic                 col6_matrix_i,  // column 6 configured as matrix
   input  wire logic [ROW_SEL_W-1:0] row_select_i,   // control register bits 14:12
   output logic                      scan_hold_o     // stop activity-driven scans
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              valid;
      logic [ROWS-1:0]   col7;
      logic [ROWS-1:0]   col6;
      logic [DATA_W-1:0] rd_data;
   } state_s;

   reg_req_s     req;
   scan_report_s rpt;
   state_s       state_reg;
   state_s       state_next;
   logic [ROWS-1:0] col7_cap;
   logic [ROWS-1:0] col6_cap;
   logic [ROWS-1:0] col7_show;
   logic [ROWS-1:0] col6_show;
   logic            hit;
   logic            accept;
   logic [DATA_W-1:0] word;

   assign req = '{addr: addr_i, wr_data: wr_data_i, wr_en: wr_en_i, rd_en: rd_en_i};
   assign rpt = '{done: scan_done_i, col7_rows: col7_rows_i, col6_rows: col6_rows_i};

   // ----------------------------------------------------------------
   // row gating at capture and at read
   // ----------------------------------------------------------------
   // gated twice so a later change of row select still hides disabled rows
   row_enable_filter u_cap7 (
      .row_select_i (row_select_i),
      .rows_i       (rpt.col7_rows),
      .rows_o       (col7_cap)
   );
   row_enable_filter u_cap6 (
      .row_select_i (row_select_i),
      .rows_i       (rpt.col6_rows),
      .rows_o       (col6_cap)
   );
   row_enable_filter u_show7 (
      .row_select_i (row_select_i),
      .rows_i       (state_reg.col7),
      .rows_o       (col7_show)
   );
   row_enable_filter u_show6 (
      .row_select_i (row_select_i),
      .rows_i       (state_reg.col6),
      .rows_o       (col6_show)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      hit        = req.rd_en && (req.addr == RESULT_OFFSET);
      word       = RESULT_RESET;
      word[VALID_BIT] = state_reg.valid;
      if (state_reg.valid) begin
         word[COL7_LSB +: ROWS] = col7_show;
         word[COL6_LSB +: ROWS] = col6_show;
      end
      // a scan reported while the flag is held is dropped, unless this cycle's
      // read releases it: the set then wins over the clear
      accept = rpt.done && (col7_matrix_i || col6_matrix_i)
               && (!state_reg.valid || hit);
      if (req.rd_en) begin
         state_next.rd_data = hit ? word : READ_NONE;
      end
      if (hit) begin
         state_next.valid = 1'b0;
      end
      if (accept) begin
         state_next.valid = 1'b1;
         state_next.col7  = col7_cap;
         state_next.col6  = col6_cap;
      end
      // writes have no effect on any field
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= '{valid: 1'b0, col7: ROWS_RESET, col6: ROWS_RESET,
                        rd_data: RESULT_RESET};
      end else begin
         state_reg <= state_next;
      end
   end

   assign rd_data_o   = state_reg.rd_data;
   assign scan_hold_o = state_reg.valid;

endmodule

`default_nettype wire

//--- testbench/keypad_matrix_model.sv
// behavioural scan engine and key matrix
`timescale 1ns/1ps
`default_nettype none
module keypad_matrix_model (
   input  wire logic       clock_i, // clock
   input  wire logic       go_i,    // run one scan
   input  wire logic [7:0] r7_i,    // keys on column 7
   input  wire logic [7:0] r6_i,    // keys on column 6
   output logic            done_o,  // scan done pulse
   output logic      [7:0] r7_o,    // column 7 hits
   output logic      [7:0] r6_o     // column 6 hits
);
   always @(posedge clock_i) begin
      done_o <= go_i;
      // junk between scans so a stale capture shows
      r7_o <= go_i ? r7_i : ~r7_o;
      r6_o <= go_i ? r6_i : ~r6_o;
   end
endmodule
`default_nettype wire

//--- testbench/scan_result_chk.sv
// port assertions for the scan result register
`timescale 1ns/1ps
`default_nettype none
module scan_result_chk
   import scan_result_pkg::*;
(
   input wire logic              clock_i,       // clock
   input wire logic              sys_rst_i,     // reset
   input wire logic [7:0]        addr_i,        // address
   input wire logic              rd_en_i,       // read
   input wire logic [31:0]       rd_data_o,     // data
   input wire logic              scan_done_i,   // done
   input wire logic              col7_matrix_i, // col 7
   input wire logic              col6_matrix_i, // col 6
   input wire logic [2:0]        row_select_i,  // rows
   input wire logic              scan_hold_o    // flag
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   wire logic hit = rd_en_i && addr_i == RESULT_OFFSET;
   wire logic take = scan_done_i && (col6_matrix_i || col7_matrix_i);
   flag_set_a: assert property (take |=> scan_hold_o) else $error("no set");
   flag_none_a: assert property (!scan_hold_o && !take |=> !scan_hold_o) else $error("set");
   flag_keep_a: assert property (scan_hold_o && !hit |=> scan_hold_o) else $error("lost");
   read_clr_a: assert property (hit && !take |=> !scan_hold_o) else $error("no clear");
   empty_rd_a: assert property (rd_en_i && !scan_hold_o |=> rd_data_o == 32'h0)
      else $error("empty read");
   rsvd_zero_a: assert property (rd_en_i |=> {rd_data_o[30:24], rd_data_o[15:8]} == 15'h0)
      else $error("reserved");
   row_mask_a: assert property (rd_en_i |=> ((rd_data_o[23:16] | rd_data_o[7:0])
      & ~(8'hFF >> (3'h7 - $past(row_select_i)))) == 8'h00) else $error("mask");
   rd_stand_a: assert property (!rd_en_i |=> $stable(rd_data_o)) else $error("moved");
endmodule
bind multikey_scan_result_cols_6_7 scan_result_chk chk (.clock_i, .sys_rst_i, .addr_i,
   .rd_en_i, .rd_data_o, .scan_done_i, .col7_matrix_i, .col6_matrix_i, .row_select_i,
   .scan_hold_o);
`default_nettype wire

//--- testbench/multikey_scan_result_cols_6_7_tb.sv
// self-checking bench for the column 6/7 scan result register
`timescale 1ns/1ps
`default_nettype none
module multikey_scan_result_cols_6_7_tb;
   import scan_result_pkg::*;
   logic        clock_i = 0, sys_rst_i = 1, wr_en_i = 0, rd_en_i = 0, go = 0, rq = 0;
   logic        c7m = 0, c6m = 0, v = 0, dn, hold;
   logic [7:0]  addr_i = 0, r7 = 0, r6 = 0, k7, k6, e7, e6;
   logic [2:0]  rs = 0;
   logic [31:0] wd = 0, rdat, q[$];
   int          err_count = 0, checks = 0;
   always #2.5 clock_i = ~clock_i;
   keypad_matrix_model pm (.clock_i, .go_i(go), .r7_i(r7), .r6_i(r6), .done_o(dn), .r7_o(k7),
      .r6_o(k6));
   multikey_scan_result_cols_6_7 dut (.clock_i, .sys_rst_i, .addr_i, .wr_data_i(wd), .wr_en_i,
      .rd_en_i, .rd_data_o(rdat), .scan_done_i(dn), .col7_rows_i(k7), .col6_rows_i(k6),
      .col7_matrix_i(c7m), .col6_matrix_i(c6m), .row_select_i(rs), .scan_hold_o(hold));
   task automatic chk(logic [31:0] g, e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   // more: another read follows at once, so the strobe is left high
   task automatic rd(logic [7:0] a, logic more);
      addr_i <= a;
      rd_en_i <= 1;
      q.push_back(a != RESULT_OFFSET || !v ? 32'h0 : {1'b1, 7'h00, e7, 8'h00, e6});
      if (a == RESULT_OFFSET) v = 0;
      @(posedge clock_i);
      if (!more) rd_en_i <= 0;
   endtask
   task automatic scan(logic [7:0] a, b);
      r7 <= a;
      r6 <= b;
      go <= 1;
      if (!v && (c6m || c7m)) begin
         v = 1;
         e7 = a & (8'hFF >> (3'h7 - rs));
         e6 = b & (8'hFF >> (3'h7 - rs));
      end
      @(posedge clock_i);
      go <= 0;
      @(posedge clock_i);
      @(negedge clock_i);
      chk({31'h0, hold}, {31'h0, v});
      @(posedge clock_i);
   endtask
   task automatic test_done;
      $display("checks %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge clock_i) rq <= rd_en_i;
   always @(negedge clock_i) if (rq) chk(rdat, q.pop_front());
   initial begin
      #60000;
      err_count++;
      test_done;
   end
   initial begin
      void'($urandom(32'h3f463477));
      repeat (10) @(posedge clock_i);
      sys_rst_i <= 0;
      @(posedge clock_i);
      rd(RESULT_OFFSET, 1'b0);
      for (int i = 0; i < 24; i++) begin
         // first two passes: no matrix column, flag must stay low
         {c7m, c6m} <= i < 2 ? 2'b00 : 2'($urandom);
         rs <= 3'($urandom);
         @(posedge clock_i);
         scan(8'($urandom), 8'($urandom));
         scan(8'($urandom), 8'($urandom));
         wd <= $urandom;
         addr_i <= RESULT_OFFSET;
         wr_en_i <= 1;
         @(posedge clock_i);
         wr_en_i <= 0;
         rd(8'($urandom) | 8'h01, 1'b1);
         rd(RESULT_OFFSET, 1'b1);
         rd(RESULT_OFFSET, 1'b0);
         @(posedge clock_i);
         $display("test %0d ended", i);
      end
      repeat (3) @(posedge clock_i);
      test_done;
   end
endmodule
`default_nettype wire
